// [flash_ctl_pkg.sv]
`default_nettype none
package flash_ctl_pkg;

   // **************
   // Array geometry
   // **************
   localparam int ADDR_W     = 24;
   localparam int BYTE_W     = 8;
   localparam int PAGE_BYTES = 256;
   localparam int PAGE_IDX_W = 8;
   localparam int SECT_IDX_W = 16;
   // Lowest pages that the protect pin locks
   localparam int PROT_PAGES = 256;
   localparam logic [BYTE_W-1:0] BYTE_ERASED = 8'hFF;

   // **************
   // Frame layout
   // **************
   // Command plus three address bytes
   localparam logic [2:0] HDR_BYTES  = 3'h4;
   localparam logic [2:0] ONE_BYTE   = 3'h1;
   localparam logic [2:0] LAST_BIT   = 3'h7;

   // **************
   // Command codes
   // **************
   localparam logic [7:0] CMD_WREN = 8'h06;
   localparam logic [7:0] CMD_WRDI = 8'h04;
   localparam logic [7:0] CMD_STATUS_READ_CMD = 8'h05;
   localparam logic [7:0] CMD_PW   = 8'h0A;
   localparam logic [7:0] CMD_PP   = 8'h02;
   localparam logic [7:0] CMD_PE   = 8'hDB;
   localparam logic [7:0] CMD_SE   = 8'hD8;
   localparam logic [7:0] CMD_DPD  = 8'hB9;
   localparam logic [7:0] CMD_RDPD = 8'hAB;

   // **************
   // Status byte fields
   // **************
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_WEL_BIT  = 1;

   // **************
   // Cycle counts at reset defaults
   // **************
   localparam int unsigned DEF_PUW_CYCLES = 1000;
   localparam int unsigned DEF_PW_CYCLES  = 1000;
   localparam int unsigned DEF_PP_CYCLES  = 100;
   localparam int unsigned DEF_PE_CYCLES  = 900;
   localparam int unsigned DEF_SE_CYCLES  = 2000;

   // **************
   // Types
   // **************
   typedef enum logic [3:0] {
      CYC_IDLE  = 4'b0001,
      CYC_FILL  = 4'b0010,
      CYC_WAIT  = 4'b0100,
      CYC_WRITE = 4'b1000
   } cycle_state_t;

   typedef enum logic [1:0] {
      OP_PW = 2'h0,
      OP_PP = 2'h1,
      OP_PE = 2'h2,
      OP_SE = 2'h3
   } op_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [BYTE_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } mem_req_t;

   typedef struct packed {
      logic busy;
      logic write_latch;
      logic deep_pd;
      logic active;
   } flash_status_t;

   localparam mem_req_t      MEM_REQ_RST = '0;
   localparam flash_status_t STATUS_RST  = '0;

endpackage
`default_nettype wire

// [pin_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   input  wire logic         ce_i,
   // Raw pins and synchronised view
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o,
   output logic      [W-1:0] rise_o,
   output logic      [W-1:0] fall_o
);

   logic [W-1:0] stage1;
   logic [W-1:0] stage2;
   logic [W-1:0] stage3;

   // Two flops per pin; third feeds edges only
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         stage1 <= '1;
         stage2 <= '1;
         stage3 <= '1;
      end else if (ce_i) begin
         stage1 <= d_i;
         stage2 <= stage1;
         stage3 <= stage2;
      end
   end

   // Edges seen in the same cycle as the level
   assign q_o    = stage2;
   assign rise_o = stage2 & ~stage3;
   assign fall_o = ~stage2 & stage3;

endmodule
`default_nettype wire

// [page_buffer.sv]
`timescale 1ns/1ps
`default_nettype none
module page_buffer
   import flash_ctl_pkg::*;
#(
   parameter int DEPTH = PAGE_BYTES,
   parameter int IDX_W = PAGE_IDX_W
) (
   // Clock and reset
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   input  wire logic              ce_i,
   // Write side
   input  wire logic              clear_i,
   input  wire logic              wr_i,
   input  wire logic              mark_i,
   input  wire logic [IDX_W-1:0]  wr_idx_i,
   input  wire logic [BYTE_W-1:0] wr_data_i,
   // Read side
   input  wire logic [IDX_W-1:0]  rd_idx_i,
   output logic      [BYTE_W-1:0] rd_data_o,
   output logic                   rd_mark_o
);

   logic [BYTE_W-1:0] data [DEPTH];
   logic [DEPTH-1:0]  mark;

   // One byte slot with its supplied marker per entry
   for (genvar g = 0; g < DEPTH; g++) begin : g_slot
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            data[g] <= BYTE_ERASED;
            mark[g] <= 1'b0;
         end else if (ce_i) begin
            if (clear_i) begin
               data[g] <= BYTE_ERASED;
               mark[g] <= 1'b0;
            end else if (wr_i && wr_idx_i == IDX_W'(g)) begin
               data[g] <= wr_data_i;
               if (mark_i) begin
                  mark[g] <= 1'b1;
               end
            end
         end
      end
   end

   // Unregistered read for the sequencer
   assign rd_data_o = data[rd_idx_i];
   assign rd_mark_o = mark[rd_idx_i];

endmodule
`default_nettype wire

// [serial_flash_write_protect_control.sv]
// Behaviour
// [RULE1] Host sends enable, then program frame
// [RULE2] At most one page per frame
// [RULE3] Host frames command, address, data bytes
// [RULE4] Data bytes land from low address
// [RULE5] Deselect starts cycle, gaps filled from page
// [RULE6] Page write erases then programs page
// [RULE7] Page program only clears bits
// [RULE8] Host should group bytes in one frame
// [RULE9] Busy flag readable for polling
// [RULE10] Host holds reset low during power-on
// [RULE11] Active while selected or cycling
// [RULE12] Power-down entered and left by command
// [RULE13] Power-down ignores all modifying commands
// [RULE14] Status read returns status bits
// [RULE15] Power-up delay blocks modification
// [RULE16] Modifying commands need whole bytes
// [RULE17] Write latch must be set first
// [RULE18] Latch cleared by reset and completions
// [RULE19] Protect pin locks lowest pages
// [RULE20] Reset pin freezes and resets logic
// [RULE21] Sample on rising, drive on falling
// [RULE22] Output driven only while selected
// [RULE23] Misframed control commands rejected
// [RULE24] Busy one during cycle, else zero
// [RULE25] Bytes travel most significant first
// [RULE26] Array commands ignored while busy
// [RULE27] Protected target rejects modification
`timescale 1ns/1ps
`default_nettype none
module serial_flash_write_protect_control #(
   parameter int unsigned PUW_CYCLES = flash_ctl_pkg::DEF_PUW_CYCLES,
   parameter int unsigned PW_CYCLES  = flash_ctl_pkg::DEF_PW_CYCLES,
   parameter int unsigned PP_CYCLES  = flash_ctl_pkg::DEF_PP_CYCLES,
   parameter int unsigned PE_CYCLES  = flash_ctl_pkg::DEF_PE_CYCLES,
   parameter int unsigned SE_CYCLES  = flash_ctl_pkg::DEF_SE_CYCLES
) (
   // Clock, reset, enable
   input  wire logic                        core_clk_i,
   input  wire logic                        reset_i,
   input  wire logic                        ce_i,
   // Serial link pins
   input  wire logic                        sclk_i,
   input  wire logic                        select_n_i,
   input  wire logic                        serial_in_i,
   output logic                             serial_out_o,
   output logic                             serial_out_oe_o,
   // Control pins
   input  wire logic                        hw_reset_n_i,
   input  wire logic                        write_protect_n_i,
   // Array port, read data one cycle after rd
   output flash_ctl_pkg::mem_req_t          mem_req_o,
   input  wire logic [flash_ctl_pkg::BYTE_W-1:0] mem_rdata_i,
   // Device state
   output flash_ctl_pkg::flash_status_t     status_o
);
   import flash_ctl_pkg::*;

   // ***********************************************
   // Pin synchronisers
   // ***********************************************
   logic [2:0] link_q;
   logic [2:0] link_rise;
   logic [2:0] link_fall;
   logic [1:0] ctl_q;

   pin_sync #(.W(3)) u_link_sync (
      .clk_i  (core_clk_i),
      .rst_i  (reset_i),
      .ce_i   (ce_i),
      .d_i    ({sclk_i, select_n_i, serial_in_i}),
      .q_o    (link_q),
      .rise_o (link_rise),
      .fall_o (link_fall)
   );

   pin_sync #(.W(2)) u_ctl_sync (
      .clk_i  (core_clk_i),
      .rst_i  (reset_i),
      .ce_i   (ce_i),
      .d_i    ({hw_reset_n_i, write_protect_n_i}),
      .q_o    (ctl_q),
      .rise_o (),
      .fall_o ()
   );

   logic sclk_rise;
   logic sclk_fall;
   logic sel_n;
   logic sel_fall;
   logic sel_rise;
   logic din;
   logic rst;
   logic wp_n;

   assign sclk_rise = link_rise[2];
   assign sclk_fall = link_fall[2];
   assign sel_n     = link_q[1];
   assign sel_fall  = link_fall[1];
   assign sel_rise  = link_rise[1];
   assign din       = link_q[0];
   // Reset pin low holds every flop outside the pin synchronisers in its reset value
   assign rst       = reset_i | ~ctl_q[1]; // [RULE20]
   assign wp_n      = ctl_q[0];

   // ***********************************************
   // Shared state
   // ***********************************************
   logic [2:0]        bit_cnt;
   logic [2:0]        byte_cnt;
   logic [6:0]        shift_in;
   logic [7:0]        cmd;
   logic [ADDR_W-1:0] addr;
   logic [7:0]        data_off;
   logic              got_data;
   logic              write_latch_flag;
   logic              busy_flag;
   logic              deep_pd;
   logic              puw_done;
   logic [31:0]       puw_cnt;
   cycle_state_t      state;
   op_t               op;
   logic [ADDR_W-1:0] base;
   logic [15:0]       cnt;
   logic [1:0]        phase;
   logic [31:0]       timer;
   logic [7:0]        tx;

   logic [7:0]        rx_byte;
   logic              byte_end;
   logic [BYTE_W-1:0] buf_rd;
   logic              buf_mark;

   assign rx_byte  = {shift_in, din};
   assign byte_end = ce_i & ~sel_n & sclk_rise & (bit_cnt == LAST_BIT);

   // ***********************************************
   // Frame receiver
   // ***********************************************
   // Rising edges only
   always_ff @(posedge core_clk_i) begin
      if (rst) begin
         bit_cnt  <= '0;
         byte_cnt <= '0;
         shift_in <= '0;
         cmd      <= '0;
         addr     <= '0;
         data_off <= '0;
         got_data <= 1'b0;
      end else if (ce_i) begin
         if (sel_fall) begin
            bit_cnt  <= '0;
            byte_cnt <= '0;
            cmd      <= '0;
            data_off <= '0;
            got_data <= 1'b0;
         end else if (!sel_n && sclk_rise) begin // [RULE21]
            shift_in <= rx_byte[6:0]; // [RULE25]
            bit_cnt  <= bit_cnt + 3'h1;
            if (bit_cnt == LAST_BIT) begin
               case (byte_cnt)
                  3'h0:    cmd          <= rx_byte;
                  3'h1:    addr[23:16]  <= rx_byte;
                  3'h2:    addr[15:8]   <= rx_byte;
                  3'h3:    addr[7:0]    <= rx_byte;
                  default: begin
                     got_data <= 1'b1;
                     // Wraps inside the page past its end
                     data_off <= data_off + 8'h01; // [RULE2]
                  end
               endcase
               if (byte_cnt != HDR_BYTES) begin
                  byte_cnt <= byte_cnt + 3'h1;
               end
            end
         end
      end
   end

   // ***********************************************
   // Command qualification at deselect
   // ***********************************************
   logic framed;
   logic one_byte;
   logic protected_hit;
   logic may_modify;
   logic wren_ok;
   logic wrdi_ok;
   logic dpd_ok;
   logic rdpd_ok;
   logic start_ok;
   op_t  start_op;
   logic cycle_done;

   // Partial byte at deselect rejects the command
   assign framed   = ce_i & sel_rise & (bit_cnt == 3'h0); // [RULE16] [RULE23]
   assign one_byte = framed & (byte_cnt == ONE_BYTE);
   // Lowest pages locked while the pin is low
   assign protected_hit = ~wp_n
      & (addr[ADDR_W-1:PAGE_IDX_W] < (ADDR_W-PAGE_IDX_W)'(PROT_PAGES)); // [RULE19]
   assign may_modify = framed & write_latch_flag & ~busy_flag // [RULE17] [RULE26]
      & ~deep_pd & puw_done & ~protected_hit; // [RULE13] [RULE15] [RULE27]

   assign wren_ok = one_byte & (cmd == CMD_WREN) & ~deep_pd;
   assign wrdi_ok = one_byte & (cmd == CMD_WRDI) & ~deep_pd;
   assign dpd_ok  = one_byte & (cmd == CMD_DPD) & ~busy_flag;
   assign rdpd_ok = one_byte & (cmd == CMD_RDPD);

   // Programs need data; erases end at address
   always_comb begin
      start_ok = 1'b0;
      start_op = OP_PW;
      case (cmd)
         CMD_PW: begin
            start_ok = may_modify & got_data; // [RULE1]
            start_op = OP_PW;
         end
         CMD_PP: begin
            start_ok = may_modify & got_data;
            start_op = OP_PP;
         end
         CMD_PE: begin
            start_ok = may_modify & (byte_cnt == HDR_BYTES) & ~got_data;
            start_op = OP_PE;
         end
         CMD_SE: begin
            start_ok = may_modify & (byte_cnt == HDR_BYTES) & ~got_data;
            start_op = OP_SE;
         end
         default: begin
            start_ok = 1'b0;
            start_op = OP_PW;
         end
      endcase
   end

   // ***********************************************
   // Write latch and power-down mode
   // ***********************************************
   // Set beats same-cycle completion
   always_ff @(posedge core_clk_i) begin
      if (rst) begin
         write_latch_flag <= 1'b0; // [RULE18]
      end else if (ce_i) begin
         if (wren_ok) begin
            write_latch_flag <= 1'b1;
         end else if (wrdi_ok || cycle_done) begin
            write_latch_flag <= 1'b0; // [RULE18]
         end
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst) begin
         deep_pd <= 1'b0;
      end else if (ce_i) begin
         if (dpd_ok) begin
            deep_pd <= 1'b1; // [RULE12]
         end else if (rdpd_ok) begin
            deep_pd <= 1'b0; // [RULE12]
         end
      end
   end

   // Modification locked until the power-up delay runs out
   always_ff @(posedge core_clk_i) begin
      if (rst) begin
         puw_cnt  <= '0;
         puw_done <= 1'b0;
      end else if (ce_i && !puw_done) begin
         puw_cnt <= puw_cnt + 32'h1;
         if (puw_cnt >= 32'(PUW_CYCLES) - 32'h1) begin
            puw_done <= 1'b1; // [RULE15]
         end
      end
   end

   // ***********************************************
   // Page buffer
   // ***********************************************
   logic              host_wr;
   logic              fill_wr;
   logic [7:0]        buf_wr_idx;
   logic [BYTE_W-1:0] buf_wr_data;
   logic [BYTE_W-1:0] merged;
   logic              buf_clear;
   logic              load_cmd;

   assign load_cmd  = (cmd == CMD_PW) | (cmd == CMD_PP);
   // Buffer owned by a running cycle, so loads are ignored while busy
   assign buf_clear = byte_end & (byte_cnt == 3'h0) & ~busy_flag
      & ((rx_byte == CMD_PW) | (rx_byte == CMD_PP));
   assign host_wr   = byte_end & (byte_cnt == HDR_BYTES) & load_cmd
      & ~busy_flag & ~deep_pd;
   assign fill_wr   = ce_i & (state == CYC_FILL) & (phase == 2'h2);
   // Program only pulls ones to zero
   assign merged    = buf_mark ? ((op == OP_PP) ? (buf_rd & mem_rdata_i) : buf_rd)
                               : mem_rdata_i; // [RULE5] [RULE7]
   assign buf_wr_idx  = host_wr ? (addr[7:0] + data_off) : cnt[7:0]; // [RULE4]
   assign buf_wr_data = host_wr ? rx_byte : merged;

   page_buffer u_buf (
      .clk_i     (core_clk_i),
      .rst_i     (rst),
      .ce_i      (ce_i),
      .clear_i   (buf_clear),
      .wr_i      (host_wr | fill_wr),
      .mark_i    (host_wr),
      .wr_idx_i  (buf_wr_idx),
      .wr_data_i (buf_wr_data),
      .rd_idx_i  (cnt[7:0]),
      .rd_data_o (buf_rd),
      .rd_mark_o (buf_mark)
   );

   // ***********************************************
   // Internal cycle sequencer
   // ***********************************************
   logic [31:0] wait_cycles;
   logic        last_byte;

   always_comb begin
      case (op)
         OP_PW:   wait_cycles = 32'(PW_CYCLES);
         OP_PP:   wait_cycles = 32'(PP_CYCLES);
         OP_PE:   wait_cycles = 32'(PE_CYCLES);
         default: wait_cycles = 32'(SE_CYCLES);
      endcase
   end

   assign last_byte  = (op == OP_SE) ? (cnt == 16'hFFFF) : (cnt[7:0] == 8'hFF);
   assign cycle_done = ce_i & (state == CYC_WRITE) & last_byte;

   // Erase time is served in the wait, then one write pass
   // stores the erased-and-programmed result
   always_ff @(posedge core_clk_i) begin
      if (rst) begin
         state     <= CYC_IDLE;
         op        <= OP_PW;
         base      <= '0;
         cnt       <= '0;
         phase     <= '0;
         timer     <= '0;
         busy_flag <= 1'b0;
         mem_req_o <= MEM_REQ_RST;
      end else if (ce_i) begin
         case (state)
            CYC_IDLE: begin
               mem_req_o.wr <= 1'b0;
               if (start_ok) begin
                  op        <= start_op;
                  base      <= addr;
                  cnt       <= '0;
                  phase     <= '0;
                  timer     <= '0;
                  busy_flag <= 1'b1; // [RULE24] [RULE9]
                  state     <= (start_op == OP_PW || start_op == OP_PP)
                               ? CYC_FILL : CYC_WAIT; // [RULE5]
               end
            end
            CYC_FILL: begin
               // Issue, hold, capture one page byte
               case (phase)
                  2'h0: begin
                     mem_req_o.rd   <= 1'b1;
                     mem_req_o.addr <= {base[ADDR_W-1:PAGE_IDX_W], cnt[7:0]};
                     phase          <= 2'h1;
                  end
                  2'h1: begin
                     mem_req_o.rd <= 1'b0;
                     phase        <= 2'h2;
                  end
                  default: begin
                     phase <= 2'h0;
                     cnt   <= cnt + 16'h1;
                     if (cnt[7:0] == 8'hFF) begin
                        cnt   <= '0;
                        state <= CYC_WAIT;
                     end
                  end
               endcase
            end
            CYC_WAIT: begin
               timer <= timer + 32'h1;
               if (timer >= wait_cycles - 32'h1) begin
                  cnt   <= '0;
                  state <= CYC_WRITE;
               end
            end
            CYC_WRITE: begin
               mem_req_o.wr    <= 1'b1;
               mem_req_o.wdata <= (op == OP_PE || op == OP_SE)
                                  ? BYTE_ERASED : buf_rd; // [RULE6]
               mem_req_o.addr  <= (op == OP_SE)
                  ? {base[ADDR_W-1:SECT_IDX_W], cnt}
                  : {base[ADDR_W-1:PAGE_IDX_W], cnt[7:0]};
               cnt <= cnt + 16'h1;
               if (last_byte) begin
                  busy_flag <= 1'b0; // [RULE24]
                  state     <= CYC_IDLE;
               end
            end
            default: begin
               state <= CYC_IDLE;
            end
         endcase
      end
   end

   // ***********************************************
   // Status output on the link
   // ***********************************************
   logic       reading;
   logic [7:0] status_byte;

   always_comb begin
      status_byte                = '0;
      status_byte[STAT_BUSY_BIT] = busy_flag;
      status_byte[STAT_WEL_BIT]  = write_latch_flag;
   end

   // Status repeats every byte for continuous polling
   assign reading = ~sel_n & (cmd == CMD_STATUS_READ_CMD) & (byte_cnt != 3'h0) & ~deep_pd; // [RULE14]

   always_ff @(posedge core_clk_i) begin
      if (rst) begin
         tx              <= '0;
         serial_out_o    <= 1'b0;
         serial_out_oe_o <= 1'b0;
      end else if (ce_i) begin
         serial_out_oe_o <= reading; // [RULE22]
         if (sclk_fall && reading) begin // [RULE21]
            if (bit_cnt == 3'h0) begin
               serial_out_o <= status_byte[7]; // [RULE25]
               tx           <= {status_byte[6:0], 1'b0};
            end else begin
               serial_out_o <= tx[7];
               tx           <= {tx[6:0], 1'b0};
            end
         end
      end
   end

   // ***********************************************
   // Device state outputs
   // ***********************************************
   always_ff @(posedge core_clk_i) begin
      if (rst) begin
         status_o <= STATUS_RST;
      end else if (ce_i) begin
         status_o.busy        <= busy_flag;
         status_o.write_latch <= write_latch_flag;
         status_o.deep_pd     <= deep_pd;
         status_o.active      <= ~sel_n | busy_flag; // [RULE11]
      end
   end

endmodule
`default_nettype wire

// [flash_ctl_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
// *******
// Checks
// *******
module flash_ctl_chk (
   // Clock and reset
   input wire logic                          core_clk_i,
   input wire logic                          reset_i,
   input wire logic                          ce_i,
   // Pins
   input wire logic                          select_n_i,
   input wire logic                          serial_out_oe_o,
   input wire logic                          write_protect_n_i,
   // Array and state
   input wire flash_ctl_pkg::mem_req_t       mem_req_o,
   input wire flash_ctl_pkg::flash_status_t  status_o
);
   import flash_ctl_pkg::*;
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (reset_i || !ce_i);
   // Allows for sync delay
   property p_oe; select_n_i [*8] |-> !serial_out_oe_o; endproperty
   a_oe: assert property (p_oe) else $error("output on while deselected");
   property p_on; !select_n_i [*6] |-> status_o.active; endproperty
   a_on: assert property (p_on) else $error("idle while selected");
   property p_off; (select_n_i && !status_o.busy) [*6] |-> !status_o.active; endproperty
   a_off: assert property (p_off) else $error("active while idle");
   // Cycle needs latch, not power-down
   property p_lat; $rose(status_o.busy) |-> status_o.write_latch && !status_o.deep_pd; endproperty
   a_lat: assert property (p_lat) else $error("cycle without latch");
   property p_clr; $fell(status_o.busy) |-> ##[0:2] !status_o.write_latch; endproperty
   a_clr: assert property (p_clr) else $error("latch kept after cycle");
   property p_wr; $rose(mem_req_o.wr) |-> status_o.busy; endproperty
   a_wr: assert property (p_wr) else $error("write pass while not busy");
   // Write pass walks the page or sector in order
   property p_inc; mem_req_o.wr && $past(mem_req_o.wr) |->
      mem_req_o.addr == $past(mem_req_o.addr) + 24'h1; endproperty
   a_inc: assert property (p_inc) else $error("write pass skipped");
   property p_wp; mem_req_o.wr && !write_protect_n_i |-> mem_req_o.addr[23:16] != 8'h00; endproperty
   a_wp: assert property (p_wp) else $error("protected page written");
endmodule
bind serial_flash_write_protect_control flash_ctl_chk i_flash_ctl_chk (.core_clk_i, .reset_i, .ce_i,
   .select_n_i, .serial_out_oe_o, .write_protect_n_i, .mem_req_o, .status_o);
`default_nettype wire

// [flash_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
// *********
// SPI host
// *********
module flash_host_model (
   // Clock
   input wire logic clk_i,
   // Link
   input wire logic miso_i,
   output var logic sclk_o,
   output var logic sel_n_o,
   output var logic mosi_o
);
   logic cpol = 1'b0;
   // Idle pins from time zero
   initial begin
      sclk_o = 1'b0;
      sel_n_o = 1'b1;
      mosi_o = 1'b0;
   end
   // Idle level moves between frames
   task automatic mode(input logic p);
      @(posedge clk_i) cpol <= p;
      sclk_o <= p;
      repeat (16) @(posedge clk_i);
   endtask
   // Frame, left-aligned, 8 cycles per half period
   task automatic frame(input logic [47:0] v, input int n, output logic [7:0] rx);
      rx = 8'h00;
      @(posedge clk_i) sel_n_o <= 1'b0;
      repeat (8) @(posedge clk_i);
      for (int i = 0; i < n; i++) begin
         sclk_o <= 1'b0;
         mosi_o <= v[47-i];
         repeat (8) @(posedge clk_i);
         sclk_o <= 1'b1;
         rx = {rx[6:0], miso_i};
         repeat (8) @(posedge clk_i);
      end
      sclk_o <= cpol;
      mosi_o <= ~mosi_o;
      repeat (8) @(posedge clk_i);
      sel_n_o <= 1'b1;
      repeat (16) @(posedge clk_i);
   endtask
endmodule
`default_nettype wire

// [test_serial_flash_write_protect_control.sv]
`timescale 1ns/1ps
`default_nettype none
module test_serial_flash_write_protect_control;
   import flash_ctl_pkg::*;
   // *******
   // Harness
   // *******
   logic          clk = 1'b0;
   logic          reset_i = 1'b1;
   logic          hw_reset_n = 1'b0;
   logic          ce = 1'b1;
   logic          wp_n = 1'b1;
   logic [7:0]    rdata = 8'hFF;
   logic [7:0]    rx;
   logic [7:0]    mem [int];
   wire logic     sclk, sel_n, mosi, sout, oe;
   mem_req_t      req;
   flash_status_t st;
   int            n_mismatch = 0;
   int            n_tests = 0;
   int            cyc = 0;
   // Short power-up, page write and program cycles, brief run
   serial_flash_write_protect_control #(.PUW_CYCLES(10), .PW_CYCLES(10), .PP_CYCLES(10))
      i_serial_flash_write_protect_control (.core_clk_i(clk),
      .reset_i(reset_i), .ce_i(ce), .sclk_i(sclk), .select_n_i(sel_n), .serial_in_i(mosi),
      .serial_out_o(sout), .serial_out_oe_o(oe), .hw_reset_n_i(hw_reset_n),
      .write_protect_n_i(wp_n), .mem_req_o(req), .mem_rdata_i(rdata), .status_o(st));
   flash_host_model i_flash_host_model (.clk_i(clk), .miso_i(sout), .sclk_o(sclk),
      .sel_n_o(sel_n), .mosi_o(mosi));
   initial forever #5 clk = ~clk;
   function automatic logic [7:0] rdm(input int a);
      return mem.exists(a) ? mem[a] : 8'hFF;
   endfunction
   // Array stand-in; data valid cycle after rd
   always @(posedge clk) begin
      rdata <= req.rd ? rdm(int'(req.addr)) : ~rdata;
      if (req.wr) mem[int'(req.addr)] = req.wdata;
      cyc++;
      if (cyc == 60000) begin
         n_mismatch++;
         wrap_up();
      end
   end
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
      end
   endtask
   task automatic f(input logic [47:0] v, input int n);
      i_flash_host_model.frame(v, n, rx);
   endtask
   task automatic sr(input logic [7:0] exp);
      f({CMD_STATUS_READ_CMD, 40'h0}, 16);
      chk(rx, exp);
   endtask
   // Poll busy, not worst case
   task automatic idle;
      for (int k = 0; k < 40; k++) begin
         f({CMD_STATUS_READ_CMD, 40'h0}, 16);
         if (rx[0] === 1'b0) break;
      end
   endtask
   task automatic t_latch;
      f({CMD_WREN, 40'h0}, 8);
      sr(8'h02);
      f({CMD_WRDI, 40'h0}, 8);
      sr(8'h00);
      f({CMD_WREN, 40'h0}, 9);
      sr(8'h00);
      $display("latch done");
   endtask
   task automatic t_prog;
      f({CMD_PP, 24'h010004, 16'h0}, 48);
      f({CMD_WREN, 40'h0}, 8);
      f({CMD_PP, 24'h010004, 16'h0FF0}, 48);
      sr(8'h03);
      idle();
      chk(rdm(32'h010004), 8'h0F);
      chk(rdm(32'h010005), 8'hF0);
      sr(8'h00);
      f({CMD_WREN, 40'h0}, 8);
      f({CMD_PP, 24'h010004, 16'hF300}, 40);
      idle();
      chk(rdm(32'h010004), 8'h03);
      f({CMD_WREN, 40'h0}, 8);
      f({CMD_PW, 24'h010005, 16'h5A00}, 40);
      idle();
      chk(rdm(32'h010005), 8'h5A);
      chk(rdm(32'h010004), 8'h03);
      chk(rdm(32'h010006), 8'hFF);
      $display("prog done");
   endtask
   task automatic t_prot;
      wp_n <= 1'b0;
      f({CMD_WREN, 40'h0}, 8);
      f({CMD_PP, 24'h000010, 16'h0}, 40);
      sr(8'h02);
      f({CMD_PP, 24'h010040, 16'h1100}, 40);
      idle();
      chk(rdm(32'h000010), 8'hFF);
      chk(rdm(32'h010040), 8'h11);
      wp_n <= 1'b1;
      $display("prot done");
   endtask
   task automatic t_pd;
      f({CMD_DPD, 40'h0}, 8);
      chk({7'h0, st.deep_pd}, 8'h01);
      f({CMD_WREN, 40'h0}, 8);
      f({CMD_RDPD, 40'h0}, 8);
      chk({7'h0, st.deep_pd}, 8'h00);
      sr(8'h00);
      $display("pd done");
   endtask
   task automatic t_misc;
      i_flash_host_model.mode(1'b1);
      f({CMD_WREN, 40'h0}, 8);
      sr(8'h02);
      ce <= 1'b0;
      f({CMD_WRDI, 40'h0}, 8);
      ce <= 1'b1;
      sr(8'h02);
      i_flash_host_model.mode(1'b0);
      hw_reset_n <= 1'b0;
      repeat (10) @(posedge clk);
      hw_reset_n <= 1'b1;
      repeat (30) @(posedge clk);
      sr(8'h00);
      $display("misc done");
   endtask
   task automatic wrap_up;
      $display("tests %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge clk);
      reset_i <= 1'b0;
      hw_reset_n <= 1'b1;
      repeat (30) @(posedge clk);
      t_latch();
      t_prog();
      t_prot();
      t_pd();
      t_misc();
      wrap_up();
   end
endmodule
`default_nettype wire
